/* common/mmu_ctl_pkg.sv */
// package: register map, field positions, reset values and decoding helpers
package mmu_ctl_pkg;
  // register byte offsets (chosen; word aligned)
  localparam logic [7:0] TWB_OFF   = 8'h00;
  localparam logic [7:0] ICTR_OFF  = 8'h04;
  localparam logic [7:0] IAP_OFF   = 8'h08;
  localparam logic [7:0] DCTR_OFF  = 8'h0C;
  localparam logic [7:0] DAP_OFF   = 8'h10;
  localparam logic [7:0] L1D_OFF   = 8'h14;
  localparam logic [7:0] STAT_OFF  = 8'h18;
  // control register bit positions, msb-0 bit n is lsb-0 bit 31-n
  localparam int GPM_BIT  = 31;
  localparam int PPM_BIT  = 30;
  localparam int CID_BIT  = 29;
  localparam int WTD_BIT  = 28;
  localparam int RSV_BIT  = 27;
  localparam int WALK_ASSIST_SIZE_BIT = 26;
  localparam int PRIVILEGE_COMPARE_MODE_BIT = 25;
  localparam int IDX_LSB  = 8;
  localparam int IDX_W    = 5;
  // tablewalk base: base in bits 31:12, index in 11:2
  localparam int TB_LSB   = 12;
  localparam int IX_LSB   = 2;
  // level-one descriptor fields
  localparam int L2_LSB   = 12;
  localparam int APG_LSB  = 5;
  localparam int G_BIT    = 4;
  localparam int PS_LSB   = 2;
  localparam int WT_BIT   = 1;
  localparam int V_BIT    = 0;
  // reset values
  localparam logic [31:0] ICTR_RST = 32'h0200_0000;
  localparam logic [31:0] DCTR_RST = 32'h0600_0000;
  localparam logic [31:0] AP_RST   = 32'h5555_5555;
  localparam logic [31:0] CTR_WMASK = 32'hFE00_1F00;
  localparam logic [4:0]  IDX_TOP32 = 5'h1F;
  localparam logic [4:0]  IDX_TOP28 = 5'h1B;
  localparam logic [1:0]  PS_8M  = 2'h3;
  localparam logic [1:0]  PS_512K = 2'h1;
  localparam logic [1:0]  PS_RSV = 2'h2;

  // effect of one protection group field
  typedef enum logic [2:0] {
    AP_NO_ACCESS, AP_CLIENT, AP_MANAGER, AP_RESERVED,
    AP_ALL_PRIV, AP_PAGE_BITS, AP_SWAP, AP_ALL_PROB
  } ap_effect_e;

  // next replacement index with wrap
  function automatic logic [4:0] idx_dec(input logic [4:0] idx, input logic rsv4);
    if (idx == 5'h00)
      return rsv4 ? IDX_TOP28 : IDX_TOP32;
    return idx - 5'h01;
  endfunction

  function automatic ap_effect_e ap_decode(input logic [1:0] f, input logic dom);
    unique case ({dom, f})
      3'b100:  return AP_NO_ACCESS;
      3'b101:  return AP_CLIENT;
      3'b110:  return AP_RESERVED;
      3'b111:  return AP_MANAGER;
      3'b000:  return AP_ALL_PRIV;
      3'b001:  return AP_PAGE_BITS;
      3'b010:  return AP_SWAP;
      default: return AP_ALL_PROB;
    endcase
  endfunction
endpackage

/* common/xlate_cfg_if.sv */
// interface: control settings handed from register file to the lookup helper
`timescale 1ns/10ps
`default_nettype none
interface xlate_cfg_if;
  logic [31:0] ictr;
  logic [31:0] dctr;
  logic [31:0] iap;
  logic [31:0] dap;
  logic [31:0] l1d;
  logic        is_instr;
  logic [2:0]  effect;
  logic [1:0]  field;
  modport regs (output ictr, dctr, iap, dap, l1d, is_instr, input effect, field);
  modport look (input ictr, dctr, iap, dap, l1d, is_instr, output effect, field);
endinterface
`default_nettype wire

/* verilog/ap_group_lookup.sv */
// protection group lookup from the descriptor's group select
`timescale 1ns/10ps
`default_nettype none
module ap_group_lookup
  import mmu_ctl_pkg::*;
(
  xlate_cfg_if.look cfg
);
  wire logic [31:0] ap_word = cfg.is_instr ? cfg.iap : cfg.dap;
  wire logic        dom     = cfg.is_instr ? cfg.ictr[GPM_BIT] : cfg.dctr[GPM_BIT];
  wire logic [3:0]  grp     = cfg.l1d[APG_LSB +: 4];
  // group 0 sits in the top two bits
  wire logic [4:0]  sh      = 5'(5'd30 - {grp, 1'b0});
  assign cfg.field  = 2'(ap_word >> sh);
  assign cfg.effect = 3'(ap_decode(cfg.field, dom));
endmodule
`default_nettype wire

/* verilog/mmu_control_regs.sv */
// memory management control registers with apb slave and translation defaults
//
// Behaviour
// - table base sets level-one table start
// - index read-only, page number by walk size
// - group mode: standard or domain manager
// - page protection: page or 1K resolution
// - instr cache default when translation off
// - data cache default when translation off
// - default write policy when cache defaulted
// - reserve bit: index wraps 32 or 28
// - privilege compare mode enables state match
// - instruction index decrements on each update
// - data index decrements on each update
// - walk size selects 1K or 4K assist
// - domain codes: none, client, reserved, manager
// - standard codes: priv, page, swap, problem
// - second table base, bits 18-19 gated
// - group select picks one of sixteen
// - page size codes small, 512K, 8M
// - descriptor write policy copyback or writethrough
// - descriptor low bit marks segment valid
`timescale 1ns/10ps
`default_nettype none
module mmu_control_regs
  import mmu_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // core side
  input  wire logic [19:0] effective_page_number_i,
  input  wire logic        instr_tlb_update_i,
  input  wire logic        data_tlb_update_i,
  input  wire logic        instr_xlate_en_i,
  input  wire logic        data_xlate_en_i,
  input  wire logic        lookup_instr_i,
  // translation results
  output logic             icache_default_on_o,
  output logic             dcache_default_on_o,
  output logic             dcache_copyback_o,
  output logic [4:0]       instr_tlb_pointer_o,
  output logic [4:0]       data_tlb_pointer_o,
  output logic             instr_priv_compare_o,
  output logic             data_priv_compare_o,
  output logic             instr_subpage_prot_o,
  output logic             data_subpage_prot_o,
  output logic             walk_4k_o,
  output logic [31:0]      l1_table_addr_o,
  output logic [31:0]      l2_table_addr_o,
  output logic             segment_valid_o,
  output logic             guarded_o,
  output logic             region_writethrough_o,
  output logic [1:0]       page_size_code_o,
  output logic             page_size_bad_o,
  output logic [2:0]       group_effect_o,
  output logic [1:0]       protection_group_field_o
);
  logic [19:0] first_table_base_reg;
  logic [31:0] ictr_reg;
  logic [31:0] dctr_reg;
  logic [31:0] iap_reg;
  logic [31:0] dap_reg;
  logic [31:0] l1d_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  xlate_cfg_if cfg ();

  ap_group_lookup u_lookup (
    .cfg (cfg.look)
  );

  // settings handed to the lookup
  assign cfg.ictr     = ictr_reg;
  assign cfg.dctr     = dctr_reg;
  assign cfg.iap      = iap_reg;
  assign cfg.dap      = dap_reg;
  assign cfg.l1d      = l1d_reg;
  assign cfg.is_instr = lookup_instr_i;

  // bus decode; writes land in the access phase only
  wire logic acc   = psel_i & penable_i;
  wire logic wr    = acc & pwrite_i;
  wire logic hit_twb  = paddr_i == TWB_OFF;
  wire logic hit_ictr = paddr_i == ICTR_OFF;
  wire logic hit_iap  = paddr_i == IAP_OFF;
  wire logic hit_dctr = paddr_i == DCTR_OFF;
  wire logic hit_dap  = paddr_i == DAP_OFF;
  wire logic hit_l1d  = paddr_i == L1D_OFF;
  wire logic hit_stat = paddr_i == STAT_OFF;
  wire logic mapped = hit_twb | hit_ictr | hit_iap | hit_dctr | hit_dap | hit_l1d | hit_stat;

  // index field live from the page number; 4K walk uses EFFECTIVE_PAGE_NUMBER[2:11]
  wire logic        walk_4k = dctr_reg[WALK_ASSIST_SIZE_BIT];
  wire logic [9:0]  first_table_index = walk_4k ? effective_page_number_i[17:8]
                                                : effective_page_number_i[19:10];
  wire logic [31:0] twb_view = {first_table_base_reg, first_table_index, 2'b00};

  // pointer next values: hardware decrement beats a software write
  wire logic [4:0] ip_cur = ictr_reg[IDX_LSB +: IDX_W];
  wire logic [4:0] dp_cur = dctr_reg[IDX_LSB +: IDX_W];
  wire logic [4:0] ip_dec = idx_dec(ip_cur, ictr_reg[RSV_BIT]);
  wire logic [4:0] dp_dec = idx_dec(dp_cur, dctr_reg[RSV_BIT]);
  wire logic [31:0] ictr_wr = (pwdata_i & CTR_WMASK) & ~(32'h1 << WTD_BIT) & ~(32'h1 << WALK_ASSIST_SIZE_BIT);
  wire logic [31:0] dctr_wr = pwdata_i & CTR_WMASK;
  wire logic [31:0] ictr_base = (wr && hit_ictr) ? ictr_wr : ictr_reg;
  wire logic [31:0] dctr_base = (wr && hit_dctr) ? dctr_wr : dctr_reg;
  wire logic [31:0] idx_mask  = ~({27'h0, 5'h1F} << IDX_LSB);
  wire logic [31:0] ictr_next = instr_tlb_update_i
                                ? ((ictr_base & idx_mask) | (32'(ip_dec) << IDX_LSB))
                                : ictr_base;
  wire logic [31:0] dctr_next = data_tlb_update_i
                                ? ((dctr_base & idx_mask) | (32'(dp_dec) << IDX_LSB))
                                : dctr_base;

  // status word: bit 8 instr enable, 7 data enable, 6 valid, 5:3 group effect
  wire logic [31:0] stat_view = {23'h0, instr_xlate_en_i, data_xlate_en_i,
                                 segment_valid_o, group_effect_o, 3'b000};
  wire logic [31:0] rd_mux =
      hit_twb  ? twb_view :
      hit_ictr ? ictr_reg :
      hit_iap  ? iap_reg  :
      hit_dctr ? dctr_reg :
      hit_dap  ? dap_reg  :
      hit_l1d  ? l1d_reg  :
      hit_stat ? stat_view : 32'h0000_0000;

  // level-one descriptor decode
  wire logic [19:0] l2_raw  = l1d_reg[31:L2_LSB];
  // msb-0 bits 18-19 are lsb-0 bits 13:12, only kept with 4K assist
  wire logic [19:0] l2_base = walk_4k ? l2_raw : {l2_raw[19:2], 2'b00};
  wire logic [1:0]  ps      = l1d_reg[PS_LSB +: 2];

  // bus answer: one access cycle, never a wait state
  wire logic        setup_cycle  = psel_i & ~penable_i;
  wire logic        rd_setup     = setup_cycle & ~pwrite_i;
  wire logic        pready_next  = setup_cycle;
  wire logic        pslverr_next = setup_cycle & ~mapped;
  // read data is caught at setup, so it stands through the access cycle
  wire logic [31:0] prdata_next  = rd_setup ? rd_mux : 32'h0000_0000;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // a write lands only at the edge where the answer is seen
  wire logic wr_take = wr & pready_reg;
  wire logic wr_twb  = wr_take & hit_twb;
  wire logic wr_iap  = wr_take & hit_iap;
  wire logic wr_dap  = wr_take & hit_dap;
  wire logic wr_l1d  = wr_take & hit_l1d;

  // a reload pulse alone still has to move the pointer
  wire logic        ictr_load             = wr_take | instr_tlb_update_i;
  wire logic        dctr_load             = wr_take | data_tlb_update_i;
  wire logic [19:0] first_table_base_next = pwdata_i[31:TB_LSB];

  // only the base bits are stored; the index is never held
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      first_table_base_reg <= 20'h00000;
    end else if (wr_twb) begin
      first_table_base_reg <= first_table_base_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ictr_reg <= ICTR_RST;
    end else if (ictr_load) begin
      ictr_reg <= ictr_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dctr_reg <= DCTR_RST;
    end else if (dctr_load) begin
      dctr_reg <= dctr_next;
    end
  end

  // both group registers share one reset pattern
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      iap_reg <= AP_RST;
    end else if (wr_iap) begin
      iap_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dap_reg <= AP_RST;
    end else if (wr_dap) begin
      dap_reg <= pwdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      l1d_reg <= 32'h0000_0000;
    end else if (wr_l1d) begin
      l1d_reg <= pwdata_i;
    end
  end

  // translation results; every output below leaves a flip-flop
  // a default cache setting only counts while its side does not translate
  wire logic        icache_on_next = ~instr_xlate_en_i & ictr_reg[CID_BIT];
  wire logic        dcache_on_next = ~data_xlate_en_i & dctr_reg[CID_BIT];
  // the write policy bit means nothing unless the data default is on
  wire logic        copyback_next  = dcache_on_next & dctr_reg[WTD_BIT];
  wire logic [31:0] l2_addr_next   = {l2_base, 12'h000};
  wire logic        size_bad_next  = ps == PS_RSV;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      icache_default_on_o <= 1'b0;
    end else begin
      icache_default_on_o <= icache_on_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dcache_default_on_o <= 1'b0;
      dcache_copyback_o   <= 1'b0;
    end else begin
      dcache_default_on_o <= dcache_on_next;
      dcache_copyback_o   <= copyback_next;
    end
  end

  // mode bits go out as they are; the core decides what they mean
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      instr_priv_compare_o <= 1'b1;
      data_priv_compare_o  <= 1'b1;
    end else begin
      instr_priv_compare_o <= ictr_reg[PRIVILEGE_COMPARE_MODE_BIT];
      data_priv_compare_o  <= dctr_reg[PRIVILEGE_COMPARE_MODE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      instr_subpage_prot_o <= 1'b0;
      data_subpage_prot_o  <= 1'b0;
    end else begin
      instr_subpage_prot_o <= ictr_reg[PPM_BIT];
      data_subpage_prot_o  <= dctr_reg[PPM_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      walk_4k_o <= 1'b1;
    end else begin
      walk_4k_o <= walk_4k;
    end
  end

  // the index part follows the page number a cycle late
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      l1_table_addr_o <= 32'h0000_0000;
    end else begin
      l1_table_addr_o <= twb_view;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      l2_table_addr_o <= 32'h0000_0000;
    end else begin
      l2_table_addr_o <= l2_addr_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      segment_valid_o       <= 1'b0;
      guarded_o             <= 1'b0;
      region_writethrough_o <= 1'b0;
    end else begin
      segment_valid_o       <= l1d_reg[V_BIT];
      guarded_o             <= l1d_reg[G_BIT];
      region_writethrough_o <= l1d_reg[WT_BIT];
    end
  end

  // a reserved size code is flagged, not mapped to a size
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      page_size_code_o <= 2'b00;
      page_size_bad_o  <= 1'b0;
    end else begin
      page_size_code_o <= ps;
      page_size_bad_o  <= size_bad_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      group_effect_o <= 3'h0;
    end else begin
      group_effect_o <= cfg.effect;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      protection_group_field_o <= 2'b00;
    end else begin
      protection_group_field_o <= cfg.field;
    end
  end

  // bus outputs and pointers are flip-flops themselves
  assign prdata_o            = prdata_reg;
  assign pready_o            = pready_reg;
  assign pslverr_o           = pslverr_reg;
  assign instr_tlb_pointer_o = ictr_reg[IDX_LSB +: IDX_W];
  assign data_tlb_pointer_o  = dctr_reg[IDX_LSB +: IDX_W];
endmodule
`default_nettype wire

/* bench/core_model.sv */
// core side model: translation enables, page number and tlb reload pulses
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // clock
  input  wire logic        mclk_i,
  // fetch and load/store side
  output logic [19:0]      effective_page_number_i,
  output logic             instr_tlb_update_i,
  output logic             data_tlb_update_i,
  output logic             instr_xlate_en_i,
  output logic             data_xlate_en_i,
  output logic             lookup_instr_i
);
  initial {effective_page_number_i, instr_tlb_update_i, data_tlb_update_i} = '0;
  initial {instr_xlate_en_i, data_xlate_en_i, lookup_instr_i} = 3'h0;
  // one reload, a single cycle wide, on exactly one side
  task automatic pulse(input logic ins);
    @(posedge mclk_i);
    {instr_tlb_update_i, data_tlb_update_i} <= {ins, !ins};
    @(posedge mclk_i);
    {instr_tlb_update_i, data_tlb_update_i} <= 2'h0;
  endtask
  task automatic drive(input logic ie, de, li, input logic [19:0] effective_page_number);
    @(posedge mclk_i);
    {instr_xlate_en_i, data_xlate_en_i, lookup_instr_i, effective_page_number_i} <= {ie, de, li, effective_page_number};
  endtask
endmodule
`default_nettype wire

/* bench/mmu_control_regs_chk.sv */
// checker: port level assertions for the translation control registers
`timescale 1ns/10ps
`default_nettype none
module mmu_control_regs_chk (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [19:0] effective_page_number_i,
  input wire logic        instr_tlb_update_i,
  input wire logic        data_tlb_update_i,
  input wire logic        instr_xlate_en_i,
  input wire logic        data_xlate_en_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        icache_default_on_o,
  input wire logic        dcache_default_on_o,
  input wire logic        dcache_copyback_o,
  input wire logic [4:0]  instr_tlb_pointer_o,
  input wire logic [4:0]  data_tlb_pointer_o,
  input wire logic        walk_4k_o,
  input wire logic [31:0] l1_table_addr_o,
  input wire logic [31:0] l2_table_addr_o,
  input wire logic [1:0]  page_size_code_o,
  input wire logic        page_size_bad_o,
  input wire logic [2:0]  group_effect_o,
  input wire logic [1:0]  protection_group_field_o
);
  logic q1, q2;
  // register writes land a cycle before the lagged walk size shows them
  wire  quiet = !q1 && !q2;
  wire  [1:0] f = protection_group_field_o;
  always_ff @(posedge mclk_i) begin
    q1 <= pready_o;
    q2 <= q1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence answer_s; psel_i && penable_i && pready_o; endsequence
  apb_answer_a: assert property (setup_s |=> answer_s) else $error("no answer to setup");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  icache_off_a: assert property (instr_xlate_en_i |=> !icache_default_on_o)
    else $error("icache default while translating");
  dcache_off_a: assert property (data_xlate_en_i |=> !dcache_default_on_o)
    else $error("dcache default while translating");
  copyback_gate_a: assert property (dcache_copyback_o |-> dcache_default_on_o)
    else $error("copyback without default cache");
  dptr_dec_a: assert property (data_tlb_update_i && data_tlb_pointer_o != 5'h00 |=>
    data_tlb_pointer_o == $past(data_tlb_pointer_o) - 5'h01) else $error("data index step");
  iptr_dec_a: assert property (instr_tlb_update_i && instr_tlb_pointer_o != 5'h00 |=>
    instr_tlb_pointer_o == $past(instr_tlb_pointer_o) - 5'h01) else $error("instr index step");
  dptr_wrap_a: assert property (data_tlb_update_i && data_tlb_pointer_o == 5'h00 |=>
    data_tlb_pointer_o inside {5'h1F, 5'h1B}) else $error("data index wrap");
  walk_index_a: assert property (quiet && $stable(effective_page_number_i) |->
    l1_table_addr_o[11:2] == (walk_4k_o ? effective_page_number_i[17:8]
    : effective_page_number_i[19:10])) else $error("table index select");
  l2_gate_a: assert property (quiet && !walk_4k_o |-> l2_table_addr_o[13:12] == 2'h0)
    else $error("second base bits not gated");
  size_bad_a: assert property (page_size_bad_o == (page_size_code_o == 2'h2))
    else $error("reserved size flag");
  domain_code_a: assert property (!group_effect_o[2] |-> group_effect_o[1:0] == {f[1], ^f})
    else $error("domain code effect");
  std_code_a: assert property (group_effect_o[2] |-> group_effect_o[1:0] == f)
    else $error("standard code effect");
endmodule
bind mmu_control_regs mmu_control_regs_chk chk (.*);
`default_nettype wire

/* bench/test_mmu_control_regs.sv */
// testbench: apb register scenarios against the translation control block
`timescale 1ns/10ps
`default_nettype none
module test_mmu_control_regs;
  import mmu_ctl_pkg::*;
  localparam logic [19:0] EPN_V = 20'hABCDE;
  logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, l1_table_addr_o, l2_table_addr_o, rd;
  logic        pready_o, pslverr_o, icache_default_on_o, dcache_default_on_o, dcache_copyback_o;
  logic        instr_priv_compare_o, data_priv_compare_o, instr_subpage_prot_o;
  logic        data_subpage_prot_o, walk_4k_o, segment_valid_o, guarded_o;
  logic        region_writethrough_o, page_size_bad_o;
  logic [4:0]  instr_tlb_pointer_o, data_tlb_pointer_o;
  logic [1:0]  page_size_code_o, protection_group_field_o;
  logic [2:0]  group_effect_o;
  wire  logic [19:0] effective_page_number_i;
  wire  logic  instr_tlb_update_i, data_tlb_update_i, instr_xlate_en_i;
  wire  logic  data_xlate_en_i, lookup_instr_i;
  int          fail_count, checks;
  mmu_control_regs uut (.*);
  core_model core (.*);
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic t_reset;
    rdc(ICTR_OFF, 32'h0200_0000);
    rdc(DCTR_OFF, 32'h0600_0000);
    rdc(IAP_OFF, 32'h5555_5555);
    rdc(DAP_OFF, 32'h5555_5555);
    rdc(8'h1C, 32'h0);
    chk(err, 1'b1);
    chk({data_priv_compare_o, walk_4k_o}, 2'h3);
    $display("reset test done");
  endtask
  task automatic t_ptr;
    apb(1'b1, DCTR_OFF, 32'h0E00_0100);
    core.pulse(1'b0);
    core.pulse(1'b0);
    settle;
    rdc(DCTR_OFF, 32'h0E00_1B00);
    apb(1'b1, ICTR_OFF, 32'h1E00_0000);
    rdc(ICTR_OFF, 32'h0A00_0000);
    core.pulse(1'b1);
    settle;
    chk({instr_tlb_pointer_o, data_tlb_pointer_o}, {5'h1B, 5'h1B});
    apb(1'b1, ICTR_OFF, 32'h0200_0000);
    core.pulse(1'b1);
    settle;
    chk(instr_tlb_pointer_o, 5'h1F);
    $display("index test done");
  endtask
  task automatic t_mode;
    apb(1'b1, ICTR_OFF, 32'h2200_0000);
    apb(1'b1, DCTR_OFF, 32'h3600_0000);
    core.drive(1'b0, 1'b0, 1'b1, EPN_V);
    settle;
    chk({icache_default_on_o, dcache_default_on_o, dcache_copyback_o}, 3'h7);
    apb(1'b1, DCTR_OFF, 32'h2600_0000);
    settle;
    chk(dcache_copyback_o, 1'b0);
    core.drive(1'b1, 1'b1, 1'b1, EPN_V);
    settle;
    chk({icache_default_on_o, dcache_default_on_o}, 2'h0);
    apb(1'b1, DCTR_OFF, 32'h4000_0000);
    apb(1'b1, ICTR_OFF, 32'h4000_0000);
    settle;
    chk({instr_priv_compare_o, data_priv_compare_o, instr_subpage_prot_o,
      data_subpage_prot_o, walk_4k_o}, 5'h06);
    apb(1'b1, DCTR_OFF, 32'h0600_0000);
    apb(1'b1, ICTR_OFF, 32'h0200_0000);
    $display("mode test done");
  endtask
  task automatic t_walk;
    core.drive(1'b0, 1'b0, 1'b1, EPN_V);
    apb(1'b1, TWB_OFF, 32'h0040_0FFF);
    rdc(TWB_OFF, {20'h0_0400, EPN_V[17:8], 2'h0});
    chk(l1_table_addr_o, {20'h0_0400, EPN_V[17:8], 2'h0});
    apb(1'b1, DCTR_OFF, 32'h0200_0000);
    settle;
    rdc(TWB_OFF, {20'h0_0400, EPN_V[19:10], 2'h0});
    $display("walk test done");
  endtask
  task automatic t_desc;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {20'h0_0403, 7'h0, !i[0], i[1:0], i[0], i[1]};
      apb(1'b1, L1D_OFF, d);
      settle;
      rdc(L1D_OFF, d);
      chk({guarded_o, page_size_code_o, region_writethrough_o, segment_valid_o}, d[4:0]);
      chk(page_size_bad_o, i == 2);
      chk(l2_table_addr_o, 32'h0040_0000);
    end
    rdc(STAT_OFF, 32'h0000_0068);
    apb(1'b1, DCTR_OFF, 32'h0600_0000);
    settle;
    chk(l2_table_addr_o, 32'h0040_3000);
    $display("descriptor test done");
  endtask
  task automatic t_group;
    logic [1:0] f;
    logic [3:0] g;
    apb(1'b1, IAP_OFF, 32'h1B00_0002);
    apb(1'b1, DAP_OFF, 32'hE4FF_FFFD);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ICTR_OFF, {m[0], 31'h0200_0000});
      apb(1'b1, DCTR_OFF, {m[0], 31'h0600_0000});
      for (int k = 0; k < 10; k++) begin
        g = (k < 8) ? 4'(k / 2) : 4'hF;
        core.drive(1'b0, 1'b0, k[0], EPN_V);
        apb(1'b1, L1D_OFF, {23'h0, g, 5'h0});
        settle;
        f = (g == 4'hF) ? 2'h2 : g[1:0];
        f = k[0] ? f : ~f;
        chk(protection_group_field_o, f);
        chk(group_effect_o, m[0] ? {1'b0, f[1], ^f} : {1'b1, f});
      end
    end
    $display("group test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {fail_count, checks} = '0;
    reset_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset;
    t_ptr;
    t_mode;
    t_walk;
    t_desc;
    t_group;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
